// File: rcr_defines.svh
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// register addresses
`define RCR_ADDR_BUCK4_CTRL 8'h42
`define RCR_ADDR_LDO5_VOLT 8'h50
`define RCR_ADDR_LDO5_CTRL 8'h51
`define RCR_ADDR_LDO6_VOLT 8'h58
`define RCR_ADDR_LDO6_CTRL 8'h59

// control register field positions
`define RCR_BIT_ENABLE 7
`define RCR_BIT_AUX 2
`define RCR_BIT_FAULT_INT_EN 1
`define RCR_BIT_PGOOD 0

// voltage register field
`define RCR_VCODE_LSB 0
`define RCR_VCODE_BITS 6

// reset values
`define RCR_CTRL_BIT_RST 1'b0
`define RCR_VCODE_RST 8'h00
`define RCR_RDATA_RST 8'h00
`define RCR_RSVD_VALUE 8'h00

`endif

// File: rcr_pkg.sv
package rcr_pkg;

    typedef enum logic [2:0] {
        RCR_SEL_NONE = 3'b000,
        RCR_SEL_BUCK4_CTRL = 3'b001,
        RCR_SEL_LDO5_VOLT = 3'b010,
        RCR_SEL_LDO5_CTRL = 3'b011,
        RCR_SEL_LDO6_VOLT = 3'b100,
        RCR_SEL_LDO6_CTRL = 3'b101
    } rcr_sel_e;

    typedef logic [7:0] rcr_byte_t;

endpackage

// File: rcr_ctrl_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defines.svh"

// one regulator control register: enable, aux bit, fault-interrupt enable, power-good
module rcr_ctrl_reg #(
    parameter bit HAS_AUX = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_pgood,
    output logic o_enable,
    output logic o_aux,
    output logic o_fault_int_en,
    output logic o_pgood,
    output logic [7:0] o_rdata
);

    logic next_enable;
    logic next_aux;
    logic next_fault_int_en;

    assign next_enable = i_wr ? i_wdata[`RCR_BIT_ENABLE] : o_enable;
    assign next_aux = (i_wr && HAS_AUX) ? i_wdata[`RCR_BIT_AUX] : o_aux;
    assign next_fault_int_en = i_wr ? i_wdata[`RCR_BIT_FAULT_INT_EN] : o_fault_int_en;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_enable <= `RCR_CTRL_BIT_RST;
            o_aux <= `RCR_CTRL_BIT_RST;
            o_fault_int_en <= `RCR_CTRL_BIT_RST;
            o_pgood <= `RCR_CTRL_BIT_RST;
        end else begin
            o_enable <= next_enable;
            o_aux <= next_aux;
            o_fault_int_en <= next_fault_int_en;
            o_pgood <= i_pgood;
        end
    end

    // reserved bits and pgood are not writable; reserved bits read zero
    always_comb begin
        o_rdata = `RCR_RSVD_VALUE;
        o_rdata[`RCR_BIT_ENABLE] = o_enable;
        o_rdata[`RCR_BIT_AUX] = o_aux;
        o_rdata[`RCR_BIT_FAULT_INT_EN] = o_fault_int_en;
        o_rdata[`RCR_BIT_PGOOD] = o_pgood;
    end

endmodule

`default_nettype wire

// File: rcr_regs.sv
// Behaviour
// - Bit 7 of each control register is a read/write enable that turns its regulator on when one and off when zero.
// - Bit 2 of the step-down control register is a read/write phase select, one for 180 degrees out of phase.
// - Bit 1 of each control register is a read/write enable that lets that regulator's faults raise an interrupt.
// - Bit 0 of each control register is a read-only power-good flag, one while the output is above threshold.
// - Bit 2 of each linear regulator control register is a read/write discharge enable used while shut down.
// - Bits 5 down to 0 of each linear regulator voltage register hold a read/write output voltage code.
`timescale 1ns/1ps
`default_nettype none
`include "rcr_defines.svh"

module rcr_regs #(
    parameter int VCODE_W = `RCR_VCODE_BITS
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [2:0] i_pgood,
    input wire logic [2:0] i_fault,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    output logic o_buck4_enable,
    output logic o_buck4_phase_180,
    output logic o_buck4_fault_interrupt_enable,
    output logic o_ldo5_enable,
    output logic o_ldo5_discharge_enable,
    output logic o_ldo5_fault_interrupt_enable,
    output logic [VCODE_W-1:0] o_ldo5_output_voltage_code,
    output logic o_ldo6_enable,
    output logic o_ldo6_discharge_enable,
    output logic o_ldo6_fault_interrupt_enable,
    output logic [VCODE_W-1:0] o_ldo6_output_voltage_code,
    output logic o_fault_irq
);

    // refuse widths and field positions that the byte layout cannot hold
    generate
        if (VCODE_W < 1 || VCODE_W > 8) begin : g_bad_vcode_w
            $error("rcr_regs: VCODE_W must lie between 1 and 8");
        end
        if (`RCR_VCODE_LSB + VCODE_W > 8) begin : g_bad_vcode_pos
            $error("rcr_regs: voltage code field runs past bit 7");
        end
        if (`RCR_BIT_ENABLE > 7 || `RCR_BIT_AUX > 7 ||
            `RCR_BIT_FAULT_INT_EN > 7 || `RCR_BIT_PGOOD > 7) begin : g_bad_ctrl_pos
            $error("rcr_regs: control field outside the byte");
        end
        if (`RCR_BIT_ENABLE == `RCR_BIT_AUX || `RCR_BIT_ENABLE == `RCR_BIT_FAULT_INT_EN ||
            `RCR_BIT_ENABLE == `RCR_BIT_PGOOD || `RCR_BIT_AUX == `RCR_BIT_FAULT_INT_EN ||
            `RCR_BIT_AUX == `RCR_BIT_PGOOD || `RCR_BIT_FAULT_INT_EN == `RCR_BIT_PGOOD) begin : g_ctrl_overlap
            $error("rcr_regs: control fields overlap");
        end
    endgenerate

    localparam logic [7:0] VCODE_RST_BYTE = `RCR_VCODE_RST;
    localparam logic [VCODE_W-1:0] VCODE_RST = VCODE_RST_BYTE[VCODE_W-1:0];

    generate
        if ((VCODE_RST_BYTE >> VCODE_W) != 8'h00) begin : g_bad_vcode_rst
            $error("rcr_regs: voltage code reset value wider than the field");
        end
    endgenerate

    // address decode
    rcr_pkg::rcr_sel_e sel;
    wire logic hit_buck4_ctrl;
    wire logic hit_ldo5_volt;
    wire logic hit_ldo5_ctrl;
    wire logic hit_ldo6_volt;
    wire logic hit_ldo6_ctrl;

    assign hit_buck4_ctrl = (i_reg_addr == `RCR_ADDR_BUCK4_CTRL);
    assign hit_ldo5_volt = (i_reg_addr == `RCR_ADDR_LDO5_VOLT);
    assign hit_ldo5_ctrl = (i_reg_addr == `RCR_ADDR_LDO5_CTRL);
    assign hit_ldo6_volt = (i_reg_addr == `RCR_ADDR_LDO6_VOLT);
    assign hit_ldo6_ctrl = (i_reg_addr == `RCR_ADDR_LDO6_CTRL);

    assign sel = hit_buck4_ctrl ? rcr_pkg::RCR_SEL_BUCK4_CTRL :
                 hit_ldo5_volt ? rcr_pkg::RCR_SEL_LDO5_VOLT :
                 hit_ldo5_ctrl ? rcr_pkg::RCR_SEL_LDO5_CTRL :
                 hit_ldo6_volt ? rcr_pkg::RCR_SEL_LDO6_VOLT :
                 hit_ldo6_ctrl ? rcr_pkg::RCR_SEL_LDO6_CTRL :
                 rcr_pkg::RCR_SEL_NONE;

    // write strobes
    wire logic wr_buck4_ctrl;
    wire logic wr_ldo5_volt;
    wire logic wr_ldo5_ctrl;
    wire logic wr_ldo6_volt;
    wire logic wr_ldo6_ctrl;

    assign wr_buck4_ctrl = i_reg_wr && (sel == rcr_pkg::RCR_SEL_BUCK4_CTRL);
    assign wr_ldo5_volt = i_reg_wr && (sel == rcr_pkg::RCR_SEL_LDO5_VOLT);
    assign wr_ldo5_ctrl = i_reg_wr && (sel == rcr_pkg::RCR_SEL_LDO5_CTRL);
    assign wr_ldo6_volt = i_reg_wr && (sel == rcr_pkg::RCR_SEL_LDO6_VOLT);
    assign wr_ldo6_ctrl = i_reg_wr && (sel == rcr_pkg::RCR_SEL_LDO6_CTRL);

    // control registers
    wire logic [7:0] rd_buck4_ctrl;
    wire logic [7:0] rd_ldo5_ctrl;
    wire logic [7:0] rd_ldo6_ctrl;

    rcr_ctrl_reg #(
        .HAS_AUX(1'b1)
    ) u_buck4_ctrl (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_wr(wr_buck4_ctrl),
        .i_wdata(i_reg_wdata),
        .i_pgood(i_pgood[0]),
        .o_enable(o_buck4_enable),
        .o_aux(o_buck4_phase_180),
        .o_fault_int_en(o_buck4_fault_interrupt_enable),
        .o_pgood(),
        .o_rdata(rd_buck4_ctrl)
    );

    rcr_ctrl_reg #(
        .HAS_AUX(1'b1)
    ) u_ldo5_ctrl (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_wr(wr_ldo5_ctrl),
        .i_wdata(i_reg_wdata),
        .i_pgood(i_pgood[1]),
        .o_enable(o_ldo5_enable),
        .o_aux(o_ldo5_discharge_enable),
        .o_fault_int_en(o_ldo5_fault_interrupt_enable),
        .o_pgood(),
        .o_rdata(rd_ldo5_ctrl)
    );

    rcr_ctrl_reg #(
        .HAS_AUX(1'b1)
    ) u_ldo6_ctrl (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_wr(wr_ldo6_ctrl),
        .i_wdata(i_reg_wdata),
        .i_pgood(i_pgood[2]),
        .o_enable(o_ldo6_enable),
        .o_aux(o_ldo6_discharge_enable),
        .o_fault_int_en(o_ldo6_fault_interrupt_enable),
        .o_pgood(),
        .o_rdata(rd_ldo6_ctrl)
    );

    // voltage code registers
    wire logic [VCODE_W-1:0] wdata_vcode;
    logic [VCODE_W-1:0] next_ldo5_vcode;
    logic [VCODE_W-1:0] next_ldo6_vcode;

    assign wdata_vcode = i_reg_wdata[`RCR_VCODE_LSB +: VCODE_W];
    assign next_ldo5_vcode = wr_ldo5_volt ? wdata_vcode : o_ldo5_output_voltage_code;
    assign next_ldo6_vcode = wr_ldo6_volt ? wdata_vcode : o_ldo6_output_voltage_code;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ldo5_output_voltage_code <= VCODE_RST;
            o_ldo6_output_voltage_code <= VCODE_RST;
        end else begin
            o_ldo5_output_voltage_code <= next_ldo5_vcode;
            o_ldo6_output_voltage_code <= next_ldo6_vcode;
        end
    end

    // voltage readback: upper bits reserved, read zero
    wire logic [7:0] rd_ldo5_volt;
    wire logic [7:0] rd_ldo6_volt;
    wire logic [7:0] vcode_pad;

    assign vcode_pad = `RCR_RSVD_VALUE;
    assign rd_ldo5_volt = vcode_pad | (8'(o_ldo5_output_voltage_code) << `RCR_VCODE_LSB);
    assign rd_ldo6_volt = vcode_pad | (8'(o_ldo6_output_voltage_code) << `RCR_VCODE_LSB);

    // read mux; unmapped addresses read zero
    wire logic [7:0] next_rdata;
    wire logic next_hit;

    assign next_rdata = (sel == rcr_pkg::RCR_SEL_BUCK4_CTRL) ? rd_buck4_ctrl :
                        (sel == rcr_pkg::RCR_SEL_LDO5_VOLT) ? rd_ldo5_volt :
                        (sel == rcr_pkg::RCR_SEL_LDO5_CTRL) ? rd_ldo5_ctrl :
                        (sel == rcr_pkg::RCR_SEL_LDO6_VOLT) ? rd_ldo6_volt :
                        (sel == rcr_pkg::RCR_SEL_LDO6_CTRL) ? rd_ldo6_ctrl :
                        `RCR_RSVD_VALUE;

    assign next_hit = (sel != rcr_pkg::RCR_SEL_NONE);

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_reg_rdata <= `RCR_RDATA_RST;
            o_reg_hit <= 1'b0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= next_rdata;
            o_reg_hit <= next_hit;
        end
    end

    // fault interrupt request, gated per regulator
    wire logic [2:0] fault_int_en;
    wire logic [2:0] fault_gated;
    wire logic next_fault_irq;

    assign fault_int_en = {o_ldo6_fault_interrupt_enable, o_ldo5_fault_interrupt_enable,
                           o_buck4_fault_interrupt_enable};
    assign fault_gated = i_fault & fault_int_en;
    assign next_fault_irq = |fault_gated;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_fault_irq <= 1'b0;
        end else begin
            o_fault_irq <= next_fault_irq;
        end
    end

endmodule

`default_nettype wire

// File: rcr_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rcr_regs_checker #(
    parameter int VCODE_W = 6
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [2:0] i_pgood,
    input wire logic [2:0] i_fault,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_hit,
    input wire logic o_buck4_enable,
    input wire logic o_buck4_phase_180,
    input wire logic o_buck4_fault_interrupt_enable,
    input wire logic o_ldo5_enable,
    input wire logic o_ldo5_fault_interrupt_enable,
    input wire logic o_ldo6_fault_interrupt_enable,
    input wire logic o_ldo6_discharge_enable,
    input wire logic [VCODE_W-1:0] o_ldo5_output_voltage_code,
    input wire logic o_fault_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    wire w42 = i_reg_wr && i_reg_addr == 8'h42;
    wire w50 = i_reg_wr && i_reg_addr == 8'h50;
    wire w51 = i_reg_wr && i_reg_addr == 8'h51;
    wire w59 = i_reg_wr && i_reg_addr == 8'h59;
    wire r42 = i_reg_rd && i_reg_addr == 8'h42;
    wire rd_v = i_reg_rd && (i_reg_addr == 8'h50 || i_reg_addr == 8'h58);
    wire [2:0] fie = {o_ldo6_fault_interrupt_enable, o_ldo5_fault_interrupt_enable, o_buck4_fault_interrupt_enable};
    AST_BUCK4_EN: assert property (w42 |=> o_buck4_enable == $past(i_reg_wdata[7]))
        else $error("buck4 enable not written");
    AST_LDO5_EN: assert property (w51 |=> o_ldo5_enable == $past(i_reg_wdata[7]))
        else $error("ldo5 enable not written");
    AST_PHASE: assert property (w42 |=> o_buck4_phase_180 == $past(i_reg_wdata[2]))
        else $error("phase bit not written");
    AST_FIE: assert property (w51 |=> o_ldo5_fault_interrupt_enable == $past(i_reg_wdata[1]))
        else $error("fault interrupt enable not written");
    AST_IRQ: assert property (##1 o_fault_irq == $past(|(i_fault & fie)))
        else $error("fault irq wrong");
    AST_PGOOD: assert property (r42 && !$past(i_srst) |=> o_reg_rdata[0] == $past(i_pgood[0], 2))
        else $error("power good read wrong");
    AST_DIS: assert property (w59 |=> o_ldo6_discharge_enable == $past(i_reg_wdata[2]))
        else $error("discharge enable not written");
    AST_VCODE: assert property (w50 |=> o_ldo5_output_voltage_code == $past(i_reg_wdata[VCODE_W-1:0]))
        else $error("voltage code not written");
    AST_RSVD: assert property (rd_v |=> o_reg_rdata[7:6] == 2'b00)
        else $error("reserved voltage bits nonzero");
    AST_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata) && $stable(o_reg_hit))
        else $error("read data changed without read");
    cover property (w42);
    cover property (i_reg_rd && i_reg_addr == 8'h43);
    cover property ($rose(o_fault_irq));
endmodule
bind rcr_regs rcr_regs_checker #(.VCODE_W(VCODE_W)) chk_u (.*);
`default_nettype wire

// File: rcr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module rcr_regs_tb;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd = 1'b0;
    logic [2:0] i_pgood = 3'h0;
    logic [2:0] i_fault = 3'h0;
    logic [7:0] rdata;
    logic hit, b_en, b_ph, b_fie, l5_en, l5_dis, l5_fie, l6_en, l6_dis, l6_fie, irq;
    logic [5:0] l5_code, l6_code;
    int mismatches = 0;
    int n_tests = 0;
    logic [7:0] adr [5] = '{8'h42, 8'h50, 8'h51, 8'h58, 8'h59};
    logic [7:0] msk [5] = '{8'h86, 8'h3f, 8'h86, 8'h3f, 8'h86};
    always #5 i_core_clk = ~i_core_clk;
    rcr_regs dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .i_pgood(i_pgood), .i_fault(i_fault),
        .o_reg_rdata(rdata), .o_reg_hit(hit), .o_buck4_enable(b_en), .o_buck4_phase_180(b_ph),
        .o_buck4_fault_interrupt_enable(b_fie), .o_ldo5_enable(l5_en), .o_ldo5_discharge_enable(l5_dis),
        .o_ldo5_fault_interrupt_enable(l5_fie), .o_ldo5_output_voltage_code(l5_code), .o_ldo6_enable(l6_en),
        .o_ldo6_discharge_enable(l6_dis), .o_ldo6_fault_interrupt_enable(l6_fie),
        .o_ldo6_output_voltage_code(l6_code), .o_fault_irq(irq));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        #1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_core_clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(adr[i]);
            `CHK("reset rdata", 8'h00, rdata)
            wr(adr[i], 8'hff);
            rd(adr[i]);
            `CHK("ones rdata", msk[i], rdata)
        end
        `CHK("buck4 controls", 3'b111, {b_en, b_ph, b_fie})
        `CHK("ldo controls", 6'h3f, {l5_en, l5_dis, l5_fie, l6_en, l6_dis, l6_fie})
        `CHK("codes", 12'hfff, {l5_code, l6_code})
        $display("test readback done");
        @(posedge i_core_clk);
        i_pgood <= 3'b101;
        repeat (2) @(posedge i_core_clk);
        for (int i = 0; i < 5; i += 2) begin
            rd(adr[i]);
            `CHK("pgood rdata", msk[i] | {7'h0, i_pgood[i/2]}, rdata)
            wr(adr[i], 8'h79);
            rd(adr[i]);
            `CHK("ro rdata", {7'h0, i_pgood[i/2]}, rdata)
        end
        $display("test pgood done");
        wr(8'h50, 8'hea);
        wr(8'h58, 8'h15);
        `CHK("codes", 12'ha95, {l5_code, l6_code})
        rd(8'h50);
        `CHK("vcode rdata", 8'h2a, rdata)
        wr(8'h42, 8'h04);
        `CHK("buck4 phase", 3'b010, {b_en, b_ph, b_fie})
        wr(8'h42, 8'h80);
        `CHK("buck4 on", 3'b100, {b_en, b_ph, b_fie})
        wr(8'h51, 8'h04);
        `CHK("ldo5 dis", 3'b010, {l5_en, l5_dis, l5_fie})
        $display("test fields done");
        wr(8'h43, 8'hff);
        rd(8'h43);
        `CHK("unmapped", 9'h000, {hit, rdata})
        rd(8'h51);
        `CHK("after unmapped", 9'h104, {hit, rdata})
        $display("test unmapped done");
        wr(8'h42, 8'h02);
        @(posedge i_core_clk);
        i_fault <= 3'b110;
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        @(posedge i_core_clk);
        i_fault <= 3'b001;
        repeat (2) @(posedge i_core_clk);
        #1;
        `CHK("irq raised", 1'b1, irq)
        $display("test irq done");
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        #1;
        `CHK("reset bus", 10'h000, {hit, rdata, irq})
        `CHK("reset controls", 9'h000, {b_en, b_ph, b_fie, l5_en, l5_dis, l5_fie, l6_en, l6_dis, l6_fie})
        `CHK("reset codes", 12'h000, {l5_code, l6_code})
        $display("test reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
